// File: hdl/pec_params.svh
// constants for the phy extended control register
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH
`define PEC_REG_ADDR 5'h10
`define PEC_BIT_UNLOCK 15
`define PEC_ADDR_MSB 10
`define PEC_ADDR_LSB 6
`define PEC_BIT_SCR_TEST 5
`define PEC_BIT_NRZI 3
`define PEC_BIT_INVALID 2
`define PEC_BIT_SCR_DIS 0
`define PEC_RST_UNLOCK 1'h0
`define PEC_RST_SCR_TEST 1'h0
`define PEC_RST_NRZI 1'h1
`define PEC_RST_INVALID 1'h0
`define PEC_RST_SCR_DIS 1'h0
`define PEC_RST_ADDR 5'h00
`define PEC_RSV_HI_MSB 14
`define PEC_RSV_HI_LSB 11
`define PEC_BIT_RSV4 4
`define PEC_BIT_RSV1 1
`define PEC_ZERO16 16'h0000
`endif

// File: hdl/pec_pkg.sv
// types for the phy extended control register
package pec_pkg;
	typedef logic [15:0] pec_word_t;
	typedef logic [4:0] pec_sym_t;
	typedef logic [3:0] pec_nib_t;
endpackage

// File: hdl/pec_ext_ctrl.sv
// phy extended control register with strap latch and transmit coding controls
// Operation
// [RULE1] writing one to bit 15 unlocks protected bits for the next write
// [RULE2] unlock bit clears itself after the next management write completes
// [RULE3] management must set the unlock again before each further protected write
// [RULE4] reserved bits 14 to 11, 4 and 1 always read zero
// [RULE5] management writes default values into reserved bits
// [RULE6] bits 10 to 6 read the five bit management address, msb at 10
// [RULE7] address straps are sampled and latched during hardware reset; the code latches them on the first clock after release
// [RULE8] software reset leaves the latched address untouched
// [RULE9] bit 5 forces descrambler out of lock; resets to zero
// [RULE10] bit 3 selects nrz or nrzi at 100 mbps; resets to one
// [RULE11] bit 2 clear keeps standard 4b/5b translation; resets to zero
// [RULE12] invalid mode with tx error maps nibbles 0 to 7 to zero-led symbols
// [RULE13] invalid mode maps 8 to b onto 00000 01101 01100 10001
// [RULE14] invalid mode maps c to f onto 10000 11001 11000 11111
// [RULE15] bit 0 bypasses scrambler and descrambler; resets to zero
// [RULE16] scrambler controls act only in 100 mbps operation
// [RULE17] at 10 mbps bits stay readable and writable without effect
`timescale 1ns/1ps
`include "pec_params.svh"
module pec_ext_ctrl (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic soft_rst_in,
	input wire logic mgmt_wr_in,
	input wire logic mgmt_rd_in,
	input wire logic [4:0] mgmt_reg_in,
	input wire logic [15:0] mgmt_wdata_in,
	output logic [15:0] mgmt_rdata_out,
	output logic override_unlock_out,
	input wire logic address_strap_msb_in,
	input wire logic address_strap_bit3_in,
	input wire logic address_strap_bit2_in,
	input wire logic address_strap_bit1_in,
	input wire logic address_strap_lsb_in,
	output logic [4:0] phy_addr_out,
	input wire logic speed_100_in,
	input wire logic [3:0] tx_nibble_in,
	input wire logic tx_er_in,
	input wire logic [4:0] tx_std_sym_in,
	output logic [4:0] tx_sym_out,
	output logic nrzi_sel_out,
	output logic scr_bypass_out,
	output logic descr_unlock_out
);
	// reset-domain state
	logic unlock_r, unlock_nxt;
	logic scr_test_r, scr_test_nxt;
	logic nrzi_r, nrzi_nxt;
	logic invalid_r, invalid_nxt;
	logic scr_dis_r, scr_dis_nxt;
	logic [4:0] addr_r, addr_nxt;
	logic strap_done_r, strap_done_nxt;
	logic [4:0] strap_s1_r, strap_s2_r;
	logic [15:0] rdata_r, rdata_nxt;
	logic [4:0] sym_r, sym_nxt;
	logic hit;

	// 4b/5b test translation for forced invalid codes
	function automatic pec_pkg::pec_sym_t inv_map(input pec_pkg::pec_nib_t n);
		case (n)
			4'h8: inv_map = 5'h00; // see [RULE13]
			4'h9: inv_map = 5'h0D;
			4'hA: inv_map = 5'h0C;
			4'hB: inv_map = 5'h11;
			4'hC: inv_map = 5'h10; // see [RULE14]
			4'hD: inv_map = 5'h19;
			4'hE: inv_map = 5'h18;
			4'hF: inv_map = 5'h1F;
			default: inv_map = {1'h0, n}; // see [RULE12]
		endcase
	endfunction

	assign hit = (mgmt_reg_in == `PEC_REG_ADDR);

	// strap pins are asynchronous to us, so two flops first; they carry no reset so they
	// keep sampling the pins while hardware reset is held, which needs at least two edges
	always_ff @(posedge ref_clk_in) begin
		strap_s1_r <= {address_strap_msb_in, address_strap_bit3_in, address_strap_bit2_in,
			address_strap_bit1_in, address_strap_lsb_in};
		strap_s2_r <= strap_s1_r;
	end

	// next-state logic for control bits and address
	always_comb begin
		unlock_nxt = unlock_r;
		scr_test_nxt = scr_test_r;
		nrzi_nxt = nrzi_r;
		invalid_nxt = invalid_r;
		scr_dis_nxt = scr_dis_r;
		addr_nxt = addr_r;
		strap_done_nxt = strap_done_r;
		// latch straps once after hardware reset release, when synced
		if (!strap_done_r) begin
			addr_nxt = strap_s2_r; // see [RULE7]
			strap_done_nxt = 1'h1;
		end
		// any management write consumes a pending unlock
		if (mgmt_wr_in && unlock_r) begin
			unlock_nxt = 1'h0; // see [RULE2]
		end
		if (mgmt_wr_in && hit) begin
			// writing here while unlocked still consumes it; a set in that write does not re-arm
			if (!unlock_r) begin
				unlock_nxt = mgmt_wdata_in[`PEC_BIT_UNLOCK]; // see [RULE1]
			end
			scr_test_nxt = mgmt_wdata_in[`PEC_BIT_SCR_TEST];
			nrzi_nxt = mgmt_wdata_in[`PEC_BIT_NRZI];
			invalid_nxt = mgmt_wdata_in[`PEC_BIT_INVALID];
			scr_dis_nxt = mgmt_wdata_in[`PEC_BIT_SCR_DIS];
		end
		// soft reset restores defaults but not the address
		if (soft_rst_in) begin
			unlock_nxt = `PEC_RST_UNLOCK;
			scr_test_nxt = `PEC_RST_SCR_TEST;
			nrzi_nxt = `PEC_RST_NRZI;
			invalid_nxt = `PEC_RST_INVALID;
			scr_dis_nxt = `PEC_RST_SCR_DIS; // see [RULE8]
		end
	end

	// register the control state
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			unlock_r <= `PEC_RST_UNLOCK;
			scr_test_r <= `PEC_RST_SCR_TEST;
			nrzi_r <= `PEC_RST_NRZI;
			invalid_r <= `PEC_RST_INVALID;
			scr_dis_r <= `PEC_RST_SCR_DIS;
			addr_r <= `PEC_RST_ADDR;
			strap_done_r <= 1'h0;
		end else begin
			unlock_r <= unlock_nxt;
			scr_test_r <= scr_test_nxt;
			nrzi_r <= nrzi_nxt;
			invalid_r <= invalid_nxt;
			scr_dis_r <= scr_dis_nxt;
			addr_r <= addr_nxt;
			strap_done_r <= strap_done_nxt;
		end
	end

	// read data and transmit symbol next values
	always_comb begin
		rdata_nxt = rdata_r;
		if (mgmt_rd_in) begin
			rdata_nxt = `PEC_ZERO16; // see [RULE4]
			if (hit) begin
				rdata_nxt[`PEC_BIT_UNLOCK] = unlock_r;
				rdata_nxt[`PEC_ADDR_MSB:`PEC_ADDR_LSB] = addr_r; // see [RULE6]
				rdata_nxt[`PEC_BIT_SCR_TEST] = scr_test_r;
				rdata_nxt[`PEC_BIT_NRZI] = nrzi_r;
				rdata_nxt[`PEC_BIT_INVALID] = invalid_r;
				rdata_nxt[`PEC_BIT_SCR_DIS] = scr_dis_r; // see [RULE17]
			end
		end
		// forced codes only on the 100 mbps path
		if (speed_100_in && invalid_r && tx_er_in) begin
			sym_nxt = inv_map(tx_nibble_in);
		end else begin
			sym_nxt = tx_std_sym_in; // see [RULE11]
		end
	end

	// register read data and symbol
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_r <= `PEC_ZERO16;
			sym_r <= 5'h00;
		end else begin
			rdata_r <= rdata_nxt;
			sym_r <= sym_nxt;
		end
	end

	// controls gated by speed; 10 mbps path sees none of them
	assign nrzi_sel_out = speed_100_in ? nrzi_r : 1'h0; // see [RULE10]
	assign scr_bypass_out = speed_100_in & scr_dis_r; // see [RULE15] see [RULE16]
	assign descr_unlock_out = speed_100_in & scr_test_r; // see [RULE9]
	assign override_unlock_out = unlock_r;
	assign phy_addr_out = addr_r;
	assign mgmt_rdata_out = rdata_r;
	assign tx_sym_out = sym_r;

	property p_unlock_once;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(unlock_r && mgmt_wr_in && !soft_rst_in) |=> !unlock_r;
	endproperty
	a_unlock_once: assert property (p_unlock_once) else $error("unlock survived a write"); // see [RULE2]

	property p_unlock_set;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(!unlock_r && mgmt_wr_in && hit && mgmt_wdata_in[`PEC_BIT_UNLOCK] && !soft_rst_in) |=> unlock_r;
	endproperty
	a_unlock_set: assert property (p_unlock_set) else $error("unlock not set"); // see [RULE1]

	property p_reserved_zero;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		$past(mgmt_rd_in) |-> (rdata_r[`PEC_RSV_HI_MSB:`PEC_RSV_HI_LSB] == 4'h0
			&& rdata_r[`PEC_BIT_RSV4] == 1'h0 && rdata_r[`PEC_BIT_RSV1] == 1'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero"); // see [RULE4]

	property p_addr_read;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(nrst_in && mgmt_rd_in && hit) |=> rdata_r[`PEC_ADDR_MSB:`PEC_ADDR_LSB] == $past(addr_r);
	endproperty
	a_addr_read: assert property (p_addr_read) else $error("address field wrong"); // see [RULE6]

	property p_addr_stable;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		strap_done_r |=> $stable(addr_r);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address changed after latch"); // see [RULE8]

	property p_strap_latch;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(nrst_in && !strap_done_r) |=> (addr_r == $past(strap_s2_r)) && strap_done_r;
	endproperty
	a_strap_latch: assert property (p_strap_latch) else $error("strap not latched"); // see [RULE7]

	property p_invalid_map;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(speed_100_in && invalid_r && tx_er_in && tx_nibble_in == 4'hD) |=> tx_sym_out == 5'h19;
	endproperty
	a_invalid_map: assert property (p_invalid_map) else $error("bad invalid symbol"); // see [RULE14]

	property p_low_nibble;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(speed_100_in && invalid_r && tx_er_in && !tx_nibble_in[3]) |=> tx_sym_out == {1'h0, $past(tx_nibble_in)};
	endproperty
	a_low_nibble: assert property (p_low_nibble) else $error("low nibble not passed"); // see [RULE12]

	property p_standard;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(nrst_in && (!invalid_r || !speed_100_in)) |=> tx_sym_out == $past(tx_std_sym_in);
	endproperty
	a_standard: assert property (p_standard) else $error("standard code not used"); // see [RULE11] see [RULE17]

	property p_speed_gate;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		!speed_100_in |-> !scr_bypass_out && !descr_unlock_out && !nrzi_sel_out;
	endproperty
	a_speed_gate: assert property (p_speed_gate) else $error("control active at 10 mbps"); // see [RULE16]

	property p_unlock_hold;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(unlock_r && !mgmt_wr_in && !soft_rst_in) |=> unlock_r;
	endproperty
	a_unlock_hold: assert property (p_unlock_hold) else $error("unlock lost without a write"); // see [RULE1]

	property p_unlock_read;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(nrst_in && mgmt_rd_in && hit) |=> rdata_r[`PEC_BIT_UNLOCK] == $past(unlock_r);
	endproperty
	a_unlock_read: assert property (p_unlock_read) else $error("unlock bit read wrong"); // see [RULE1]

	property p_soft_addr;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(soft_rst_in && strap_done_r) |=> addr_r == $past(addr_r);
	endproperty
	a_soft_addr: assert property (p_soft_addr) else $error("soft reset moved the address"); // see [RULE8]

	property p_ctrl_write;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(nrst_in && mgmt_wr_in && hit && !soft_rst_in) |=> (nrzi_r == $past(mgmt_wdata_in[`PEC_BIT_NRZI]))
			&& (invalid_r == $past(mgmt_wdata_in[`PEC_BIT_INVALID]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("coding bits not written"); // see [RULE10] see [RULE11]

	property p_nrzi_out;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		speed_100_in |-> nrzi_sel_out == nrzi_r;
	endproperty
	a_nrzi_out: assert property (p_nrzi_out) else $error("line coding select wrong"); // see [RULE10]

	property p_bypass_out;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		speed_100_in |-> scr_bypass_out == scr_dis_r;
	endproperty
	a_bypass_out: assert property (p_bypass_out) else $error("scrambler bypass wrong"); // see [RULE15]

	property p_descr_out;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		speed_100_in |-> descr_unlock_out == scr_test_r;
	endproperty
	a_descr_out: assert property (p_descr_out) else $error("descrambler test wrong"); // see [RULE9]

	property p_err_off;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(nrst_in && !tx_er_in) |=> tx_sym_out == $past(tx_std_sym_in);
	endproperty
	a_err_off: assert property (p_err_off) else $error("forced code without tx error"); // see [RULE11]

	property p_nibble_b;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(speed_100_in && invalid_r && tx_er_in && tx_nibble_in == 4'hB) |=> tx_sym_out == 5'h11;
	endproperty
	a_nibble_b: assert property (p_nibble_b) else $error("bad symbol for nibble b"); // see [RULE13]

	property p_nibble_f;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(speed_100_in && invalid_r && tx_er_in && tx_nibble_in == 4'hF) |=> tx_sym_out == 5'h1F;
	endproperty
	a_nibble_f: assert property (p_nibble_f) else $error("bad symbol for nibble f"); // see [RULE14]
endmodule // pec_ext_ctrl

// File: test/pec_sta_model.sv
// station management model driving the register port
`timescale 1ns/1ps
module pec_sta_model (
	input wire logic ref_clk_in,
	output logic mgmt_wr_out,
	output logic mgmt_rd_out,
	output logic [4:0] mgmt_reg_out,
	output logic [15:0] mgmt_wdata_out,
	input wire logic [15:0] mgmt_rdata_in
);
	// idle bus from time zero
	initial begin
		mgmt_wr_out = 1'h0;
		mgmt_rd_out = 1'h0;
		mgmt_reg_out = 5'h00;
		mgmt_wdata_out = 16'hA5A5;
	end
	// one write; data is inverted after release so a stale word never looks valid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk_in);
		mgmt_wr_out <= 1'h1;
		mgmt_reg_out <= a;
		mgmt_wdata_out <= (a == 5'h10) ? (d & 16'h87ED) : d;
		@(posedge ref_clk_in);
		mgmt_wr_out <= 1'h0;
		mgmt_wdata_out <= ~d;
	endtask
	// one read; data is taken once the registered answer has settled
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk_in);
		mgmt_rd_out <= 1'h1;
		mgmt_reg_out <= a;
		@(posedge ref_clk_in);
		mgmt_rd_out <= 1'h0;
		@(negedge ref_clk_in);
		d = mgmt_rdata_in;
	endtask
endmodule // pec_sta_model

// File: test/phy_extended_control_test.sv
// self-checking bench for the phy extended control register
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module phy_extended_control_test;
	logic ref_clk_in, nrst_in, soft_rst_in, speed_100_in, tx_er, wr, rd, unl, nrzi, byp, dul;
	logic [4:0] reg_n, std, sym, addr, strap;
	logic [3:0] nib;
	logic [15:0] wd, rdat;
	pec_pkg::pec_word_t got;
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;
	localparam logic [4:0] STRAP = 5'h15;
	localparam logic [4:0] MAP [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
	pec_sta_model sta (.ref_clk_in(ref_clk_in), .mgmt_wr_out(wr), .mgmt_rd_out(rd), .mgmt_reg_out(reg_n),
		.mgmt_wdata_out(wd), .mgmt_rdata_in(rdat));
	pec_ext_ctrl dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .soft_rst_in(soft_rst_in), .mgmt_wr_in(wr),
		.mgmt_rd_in(rd), .mgmt_reg_in(reg_n), .mgmt_wdata_in(wd), .mgmt_rdata_out(rdat),
		.override_unlock_out(unl), .address_strap_msb_in(strap[4]), .address_strap_bit3_in(strap[3]),
		.address_strap_bit2_in(strap[2]), .address_strap_bit1_in(strap[1]), .address_strap_lsb_in(strap[0]),
		.phy_addr_out(addr), .speed_100_in(speed_100_in), .tx_nibble_in(nib), .tx_er_in(tx_er),
		.tx_std_sym_in(std), .tx_sym_out(sym), .nrzi_sel_out(nrzi), .scr_bypass_out(byp),
		.descr_unlock_out(dul));
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one transmit nibble, symbol judged one cycle later
	task automatic tx(input logic [3:0] n, input logic e, input logic [4:0] x);
		@(posedge ref_clk_in);
		nib <= n;
		tx_er <= e;
		std <= {1'h1, ~n};
		@(posedge ref_clk_in);
		#1 `CHK(sym, x)
	endtask
	task automatic t_reset();
		`CHK(addr, STRAP)
		sta.rd(5'h10, got);
		`CHK(got, {5'h00, STRAP, 6'h08})
		`CHK({unl, nrzi, byp, dul}, 4'h4)
	endtask
	// unlock survives a read, clears after any write, must be set again
	task automatic t_unlock();
		sta.wr(5'h10, 16'hFFFF);
		#1 `CHK(unl, 1'h1)
		sta.rd(5'h10, got);
		`CHK(got, {5'h10, STRAP, 6'h2D})
		`CHK({unl, nrzi, byp, dul}, 4'hF)
		sta.wr(5'h00, 16'h0000);
		#1 `CHK(unl, 1'h0)
		sta.wr(5'h10, 16'h8000);
		#1 `CHK(unl, 1'h1)
		`CHK(nrzi, 1'h0)
		sta.wr(5'h01, 16'h0000);
		#1 `CHK(unl, 1'h0)
	endtask
	// software reset restores controls, keeps the address
	// straps move first so a relatch on soft reset would show
	task automatic t_soft();
		@(posedge ref_clk_in);
		strap <= 5'h0A;
		sta.wr(5'h10, 16'h002D);
		@(posedge ref_clk_in);
		soft_rst_in <= 1'h1;
		@(posedge ref_clk_in);
		soft_rst_in <= 1'h0;
		sta.rd(5'h10, got);
		`CHK(got, {5'h00, STRAP, 6'h08})
		`CHK(addr, STRAP)
	endtask
	task automatic t_code();
		tx(4'h9, 1'h1, 5'h16);
		sta.wr(5'h10, 16'h0004);
		for (int n = 0; n < 16; n++) tx(4'(n), 1'h1, MAP[n]);
		tx(4'h9, 1'h0, 5'h16);
	endtask
	// at 10 Mbps the bits read back but act on nothing
	task automatic t_slow();
		sta.wr(5'h10, 16'h002D);
		speed_100_in <= 1'h0;
		tx(4'h9, 1'h1, 5'h16);
		`CHK({nrzi, byp, dul}, 3'h0)
		sta.rd(5'h10, got);
		`CHK(got, {5'h00, STRAP, 6'h2D})
	endtask
	// hardware reset in mid-run relatches the moved straps and restores every control
	task automatic t_hw();
		sta.wr(5'h10, 16'h002D);
		@(posedge ref_clk_in);
		speed_100_in <= 1'h1;
		nrst_in <= 1'h0;
		repeat (2) @(posedge ref_clk_in);
		nrst_in <= 1'h1;
		repeat (2) @(posedge ref_clk_in);
		#1 `CHK(addr, 5'h0A)
		`CHK({unl, nrzi, byp, dul}, 4'h4)
		sta.rd(5'h10, got);
		`CHK(got, {5'h00, 5'h0A, 6'h08})
	endtask
	initial begin
		ref_clk_in = 1'h0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	// hang guard, far above the roughly 80 cycles needed
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		{nrst_in, soft_rst_in, tx_er, nib, std} = '0;
		strap = STRAP;
		speed_100_in = 1'h1;
		repeat (2) @(posedge ref_clk_in);
		nrst_in <= 1'h1;
		repeat (3) @(posedge ref_clk_in);
		t_reset();
		t_unlock();
		t_soft();
		t_code();
		t_slow();
		t_hw();
		test_done();
	end
endmodule // phy_extended_control_test
